// ### design/icpfg_pkg.sv
// Package for the isolated CAN transceiver fault guard
package icpfg_pkg;
	// Internal timebase
	localparam int unsigned CLK_HZ           = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS    = 100;
	// Watchdog limit in microseconds; must sit within 1200..3800
	localparam int unsigned DOM_TIMEOUT_US   = 2000;
	localparam int unsigned DOM_TIMEOUT_CYC  = DOM_TIMEOUT_US * (CLK_HZ / 1_000_000);
	// Supply recovery delay in microseconds
	localparam int unsigned RECOVERY_US      = 300;
	localparam int unsigned RECOVERY_CYC     = RECOVERY_US * (CLK_HZ / 1_000_000);
	localparam int unsigned MAX_DOM_BITS     = 11;
	localparam int unsigned CNT_W            = 16;
	localparam int unsigned FIFO_DEPTH       = 4;
	localparam logic        TX_RESET_VAL     = 1'b1;
	localparam logic        RX_RESET_VAL     = 1'b1;

	// Supply and thermal monitor flags
	typedef struct packed {
		logic thermal_trip;
		logic logic_side_undervolt;
		logic bus_side_undervolt;
	} icpfg_mon_t;

	// Word carried through the receive FIFO
	typedef struct packed {
		logic bus_dominant;
		logic guard_active;
	} icpfg_rx_t;

	typedef enum logic [2:0] {
		ST_PROT  = 3'b001,
		ST_RECOV = 3'b010,
		ST_FUNC  = 3'b100
	} icpfg_st_t;
endpackage

// ### design/icpfg_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
module icpfg_fifo #(
	parameter int unsigned WIDTH = 2,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_q[rd_q];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ### design/icpfg_top.sv
// Digital control of an isolated CAN transceiver with driver fault guards
// Notes on behaviour
// - Low transmit drives dominant; high leaves recessive
// - Receive output low dominant, high recessive
// - Watchdog starts on each transmit falling edge
// - Timeout without rising edge disables driver
// - Recessive transmit clears timeout, re-enables driver
// - Receive path and recessive bias during timeout
// - Over-temperature turns driver off, receiver stays
// - Thermal shutdown latched until release margin reached
// - Both supplies good: fully functional
// - Either undervoltage gives protected state
// - Bus supply low: outputs off, receive high
// - Recovery delay after undervoltage clears
module icpfg_top
	import icpfg_pkg::*;
#(
	parameter int unsigned DOM_CYC = DOM_TIMEOUT_CYC,
	parameter int unsigned REC_CYC = RECOVERY_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       host_tx_i,
	output logic            host_rx_o,
	input  wire logic       bus_dominant_i,
	input  wire icpfg_mon_t mon_i,
	input  wire logic       thermal_release_margin_i,
	output logic            drv_dominant_o,
	output logic            bias_recessive_o,
	output logic            bus_hiz_o,
	output logic            dominant_watchdog_o,
	output logic            thermal_trip_o,
	output logic            functional_o,
	output logic            rx_overflow_o
);
	logic [1:0]      tx_sync_q;
	logic            tx_q;
	logic            tx_fall;
	icpfg_mon_t      mon_s1_q;
	icpfg_mon_t      mon_q;
	logic            rel_s1_q;
	logic            rel_q;
	logic [CNT_W-1:0] dom_cnt_q;
	logic            dom_to_q;
	logic            tsd_q;
	icpfg_st_t       st_q;
	logic [CNT_W-1:0] rec_cnt_q;
	logic            drv_en;
	logic            in_ready;
	icpfg_rx_t       rx_word;
	icpfg_rx_t       rx_out;
	logic            rx_valid;

	// Transmit is two-stage synchronized; edge logic compares the second stage with its delayed copy tx_q
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_sync_q <= {TX_RESET_VAL, TX_RESET_VAL};
			tx_q      <= TX_RESET_VAL;
		end else begin
			tx_sync_q <= {tx_sync_q[0], host_tx_i};
			tx_q      <= tx_sync_q[1];
		end
	end
	assign tx_fall = tx_q && !tx_sync_q[1];

	// Monitor flags are synchronized; first stage feeds only the second
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mon_s1_q <= '{thermal_trip: 1'b0, logic_side_undervolt: 1'b1, bus_side_undervolt: 1'b1};
			mon_q    <= '{thermal_trip: 1'b0, logic_side_undervolt: 1'b1, bus_side_undervolt: 1'b1};
			rel_s1_q <= 1'b0;
			rel_q    <= 1'b0;
		end else begin
			mon_s1_q <= mon_i;
			mon_q    <= mon_s1_q;
			rel_s1_q <= thermal_release_margin_i;
			rel_q    <= rel_s1_q;
		end
	end

	// Dominant watchdog; a stuck low host cannot hold the bus forever
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dom_cnt_q <= '0;
			dom_to_q  <= 1'b0;
		end else if (tx_sync_q[1]) begin
			dom_cnt_q <= '0;
			dom_to_q  <= 1'b0;
		end else if (tx_fall) begin
			dom_cnt_q <= CNT_W'(1);
		end else if (!dom_to_q) begin
			if (dom_cnt_q >= CNT_W'(DOM_CYC - 1)) begin
				dom_to_q <= 1'b1;
			end else begin
				dom_cnt_q <= dom_cnt_q + CNT_W'(1);
			end
		end
	end

	// Thermal shutdown latch; the set wins over the release
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tsd_q <= 1'b0;
		end else if (mon_q.thermal_trip) begin
			tsd_q <= 1'b1;
		end else if (rel_q) begin
			tsd_q <= 1'b0;
		end
	end

	// Supply state; resets into protected and waits out the recovery delay
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q      <= ST_PROT;
			rec_cnt_q <= '0;
		end else if (mon_q.logic_side_undervolt || mon_q.bus_side_undervolt) begin
			st_q      <= ST_PROT;
			rec_cnt_q <= '0;
		end else begin
			unique case (st_q)
				ST_PROT: begin
					st_q      <= ST_RECOV;
					rec_cnt_q <= '0;
				end
				ST_RECOV: begin
					if (rec_cnt_q >= CNT_W'(REC_CYC - 1)) begin
						st_q <= ST_FUNC;
					end else begin
						rec_cnt_q <= rec_cnt_q + CNT_W'(1);
					end
				end
				ST_FUNC: begin
					st_q <= ST_FUNC;
				end
				default: begin
					st_q <= ST_PROT;
				end
			endcase
		end
	end

	// Supply flags gate directly, so the driver never outlives a supply fault by one cycle
	assign drv_en = (st_q == ST_FUNC) && !dom_to_q && !tsd_q
		&& !mon_q.logic_side_undervolt && !mon_q.bus_side_undervolt;

	// Driver outputs registered; bus follows transmit only when all guards are clear
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			drv_dominant_o   <= 1'b0;
			bias_recessive_o <= 1'b0;
			bus_hiz_o        <= 1'b1;
		end else begin
			drv_dominant_o   <= drv_en && !tx_sync_q[1];
			bias_recessive_o <= !mon_q.bus_side_undervolt;
			bus_hiz_o        <= mon_q.bus_side_undervolt;
		end
	end

	// Receive samples pass a short FIFO; drain stalls only while not functional
	assign rx_word = '{bus_dominant: bus_dominant_i, guard_active: dom_to_q || tsd_q};

	icpfg_fifo #(
		.WIDTH ($bits(icpfg_rx_t)),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.in_data_i   (rx_word),
		.in_valid_i  (1'b1),
		.in_ready_o  (in_ready),
		.out_data_o  (rx_out),
		.out_valid_o (rx_valid),
		.out_ready_i (st_q == ST_FUNC)
	);

	// Bus supply low forces receive high; so does any state but functional, which logic supply low brings
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			host_rx_o     <= RX_RESET_VAL;
			rx_overflow_o <= 1'b0;
		end else begin
			rx_overflow_o <= !in_ready;
			if (mon_q.bus_side_undervolt || st_q != ST_FUNC) begin
				host_rx_o <= RX_RESET_VAL;
			end else if (rx_valid) begin
				host_rx_o <= !rx_out.bus_dominant;
			end
		end
	end

	assign dominant_watchdog_o = dom_to_q;
	assign thermal_trip_o      = tsd_q;
	assign functional_o        = (st_q == ST_FUNC);

	property p_tx_dom;
		@(posedge clk_i) disable iff (!nrst_i)
		(drv_en && !tx_sync_q[1]) |=> drv_dominant_o;
	endproperty
	a_tx_dom: assert property (p_tx_dom) else $error("dominant not driven");

	property p_rx_high_prot;
		@(posedge clk_i) disable iff (!nrst_i)
		(st_q != ST_FUNC) |=> host_rx_o;
	endproperty
	a_rx_high_prot: assert property (p_rx_high_prot) else $error("rx not high");

	property p_timeout;
		@(posedge clk_i) disable iff (!nrst_i)
		(dom_cnt_q == CNT_W'(DOM_CYC - 1) && !tx_sync_q[1] && !tx_fall) |=> dom_to_q;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout missed");

	property p_clear;
		@(posedge clk_i) disable iff (!nrst_i)
		tx_sync_q[1] |=> !dom_to_q;
	endproperty
	a_clear: assert property (p_clear) else $error("timeout not cleared");

	property p_restart;
		@(posedge clk_i) disable iff (!nrst_i)
		tx_fall |=> (dom_cnt_q == CNT_W'(1));
	endproperty
	a_restart: assert property (p_restart) else $error("timer not restarted");

	property p_guard_off;
		@(posedge clk_i) disable iff (!nrst_i)
		(dom_to_q || tsd_q) |=> !drv_dominant_o;
	endproperty
	a_guard_off: assert property (p_guard_off) else $error("driver active in fault");

	property p_tsd_hold;
		@(posedge clk_i) disable iff (!nrst_i)
		(tsd_q && !rel_q) |=> tsd_q;
	endproperty
	a_tsd_hold: assert property (p_tsd_hold) else $error("thermal released early");

	property p_uv_prot;
		@(posedge clk_i) disable iff (!nrst_i)
		(mon_q.logic_side_undervolt || mon_q.bus_side_undervolt) |=> (st_q == ST_PROT);
	endproperty
	a_uv_prot: assert property (p_uv_prot) else $error("not protected");

	property p_hiz;
		@(posedge clk_i) disable iff (!nrst_i)
		mon_q.bus_side_undervolt |=> (bus_hiz_o && !drv_dominant_o);
	endproperty
	a_hiz: assert property (p_hiz) else $error("bus not released");

	property p_recover;
		@(posedge clk_i) disable iff (!nrst_i)
		$rose(st_q == ST_RECOV) |-> (st_q != ST_FUNC) [*8];
	endproperty
	a_recover: assert property (p_recover) else $error("recovery too short");

	property p_tx_recess;
		@(posedge clk_i) disable iff (!nrst_i)
		tx_sync_q[1] |=> !drv_dominant_o;
	endproperty
	a_tx_recess: assert property (p_tx_recess) else $error("driven while recessive");

	property p_rx_mirror;
		@(posedge clk_i) disable iff (!nrst_i)
		(st_q == ST_FUNC && !mon_q.bus_side_undervolt && rx_valid)
			|=> (host_rx_o == !$past(rx_out.bus_dominant));
	endproperty
	a_rx_mirror: assert property (p_rx_mirror) else $error("rx not mirroring");

	property p_wd_len;
		@(posedge clk_i) disable iff (!nrst_i)
		$rose(dom_to_q) |-> (dom_cnt_q == CNT_W'(DOM_CYC - 1));
	endproperty
	a_wd_len: assert property (p_wd_len) else $error("timeout at wrong count");

	property p_cnt_run;
		@(posedge clk_i) disable iff (!nrst_i)
		(!tx_sync_q[1] && !tx_fall && !dom_to_q && dom_cnt_q < CNT_W'(DOM_CYC - 1))
			|=> (dom_cnt_q == $past(dom_cnt_q) + CNT_W'(1));
	endproperty
	a_cnt_run: assert property (p_cnt_run) else $error("timer not counting");

	property p_wd_hold;
		@(posedge clk_i) disable iff (!nrst_i)
		(dom_to_q && !tx_sync_q[1]) |=> dom_to_q;
	endproperty
	a_wd_hold: assert property (p_wd_hold) else $error("timeout dropped early");

	property p_wd_bias;
		@(posedge clk_i) disable iff (!nrst_i)
		(dom_to_q && !mon_q.bus_side_undervolt) |=> bias_recessive_o;
	endproperty
	a_wd_bias: assert property (p_wd_bias) else $error("bias lost in timeout");

	property p_rx_wd;
		@(posedge clk_i) disable iff (!nrst_i)
		(dom_to_q && st_q == ST_FUNC && !mon_q.bus_side_undervolt && rx_valid)
			|=> (host_rx_o == !$past(rx_out.bus_dominant));
	endproperty
	a_rx_wd: assert property (p_rx_wd) else $error("rx frozen in timeout");

	property p_tsd_set;
		@(posedge clk_i) disable iff (!nrst_i)
		mon_q.thermal_trip |=> tsd_q;
	endproperty
	a_tsd_set: assert property (p_tsd_set) else $error("thermal trip missed");

	property p_rx_tsd;
		@(posedge clk_i) disable iff (!nrst_i)
		(tsd_q && st_q == ST_FUNC && !mon_q.bus_side_undervolt && rx_valid)
			|=> (host_rx_o == !$past(rx_out.bus_dominant));
	endproperty
	a_rx_tsd: assert property (p_rx_tsd) else $error("rx frozen in thermal");

	property p_tsd_release;
		@(posedge clk_i) disable iff (!nrst_i)
		(tsd_q && rel_q && !mon_q.thermal_trip) |=> !tsd_q;
	endproperty
	a_tsd_release: assert property (p_tsd_release) else $error("thermal stuck");

	property p_bias_ok;
		@(posedge clk_i) disable iff (!nrst_i)
		!mon_q.bus_side_undervolt |=> (bias_recessive_o && !bus_hiz_o);
	endproperty
	a_bias_ok: assert property (p_bias_ok) else $error("bias missing");

	property p_prot_drv;
		@(posedge clk_i) disable iff (!nrst_i)
		(st_q != ST_FUNC) |=> !drv_dominant_o;
	endproperty
	a_prot_drv: assert property (p_prot_drv) else $error("driven while protected");

	property p_mon_sync;
		@(posedge clk_i) disable iff (!nrst_i)
		1'b1 |=> (mon_s1_q == $past(mon_i) && mon_q == $past(mon_s1_q));
	endproperty
	a_mon_sync: assert property (p_mon_sync) else $error("monitor sync broken");

	property p_tx_sync;
		@(posedge clk_i) disable iff (!nrst_i)
		1'b1 |=> (tx_sync_q[1] == $past(tx_sync_q[0]));
	endproperty
	a_tx_sync: assert property (p_tx_sync) else $error("transmit sync broken");

	c_timeout: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(dom_to_q));
	c_thermal: cover property (@(posedge clk_i) disable iff (!nrst_i) $fell(tsd_q));
	c_func:    cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(st_q == ST_FUNC));
	c_dom:     cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(drv_dominant_o));
	c_hiz:     cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(bus_hiz_o));
endmodule

// ### sim/icpfg_host_model.sv
// Host CAN controller model driving the transmit line
module icpfg_host_model (
	input  wire logic clk_i,
	input  wire logic rx_i,
	output logic      tx_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idles recessive, as the board pull-up would leave it
	initial tx_o = 1'h1;

	// Holds one level for n cycles; the random frame loop caps dominant runs at eleven bits
	task automatic send(input logic b, input int n);
		@(negedge clk_i);
		tx_o = b;
		repeat (n - 1) @(negedge clk_i);
	endtask
endmodule

// ### sim/icpfg_top_tb.sv
// Self-checking bench for the isolated CAN transceiver fault guard
module icpfg_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import icpfg_pkg::*;

	// Short counts keep the run brief; 11 bits of 5 cycles stay under DOM
	localparam int DOM = 60;
	localparam int REC = 10;

	logic       clk, nrst, host_tx, bus, rel, b, e_wd, e_th;
	icpfg_mon_t mon;
	wire  [7:0] outs;
	logic [7:0] exp_q[$];
	int         fails, cmp_count, seed, n, run;
	event       smp;

	icpfg_top #(.DOM_CYC(DOM), .REC_CYC(REC)) dut (
		.clk_i(clk), .nrst_i(nrst), .host_tx_i(host_tx), .host_rx_o(outs[0]),
		.bus_dominant_i(bus), .mon_i(mon), .thermal_release_margin_i(rel),
		.drv_dominant_o(outs[7]), .bias_recessive_o(outs[6]), .bus_hiz_o(outs[5]),
		.dominant_watchdog_o(outs[4]), .thermal_trip_o(outs[3]),
		.functional_o(outs[2]), .rx_overflow_o(outs[1])
	);

	icpfg_host_model host (.clk_i(clk), .rx_i(outs[0]), .tx_o(host_tx));

	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] ex);
		cmp_count++;
		if (seen !== ex) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, ex, seen);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Order: drv, bias, hiz, watchdog, thermal, functional, overflow, rx
	function automatic logic [7:0] exv();
		logic f;
		f = !mon.logic_side_undervolt && !mon.bus_side_undervolt;
		return {f && !e_wd && !e_th && !host_tx, !mon.bus_side_undervolt,
			mon.bus_side_undervolt, e_wd, e_th, f, !f, f ? !bus : 1'h1};
	endfunction

	task automatic note(input logic [7:0] ex);
		exp_q.push_back(ex);
		-> smp;
	endtask

	always @(smp) check("outputs", outs, exp_q.pop_front());

	task automatic chk(input int k);
		repeat (k) @(negedge clk);
		note(exv());
	endtask

	// Bounded wait; a late or missing recovery counts against the run
	task automatic wait_func();
		n = 0;
		while (outs[2] !== 1'h1 && n < REC + 20) begin
			@(negedge clk);
			n++;
		end
		check("recovery", 8'(n >= REC && n <= REC + 8), 8'h01);
		if (outs[2] !== 1'h1)
			conclude();
	endtask

	initial begin
		seed = 59;
		fails = 0;
		cmp_count = 0;
		e_wd = 1'h0;
		e_th = 1'h0;
		nrst = 1'h0;
		bus = 1'h0;
		rel = 1'h1;
		mon = '0;
		repeat (5) @(negedge clk);
		note(8'h21);
		nrst = 1'h1;
		wait_func();
		$display("Test reset done");
		run = 0;
		for (int i = 0; i < 40; i++) begin
			{b, bus} = 2'($random(seed));
			run = b ? 0 : run + 1;
			if (run > 11) begin
				b = 1'h1;
				run = 0;
			end
			host.send(b, 5);
			note(exv());
		end
		$display("Test frame done");
		host.send(1'h1, 5);
		host.send(1'h0, DOM - 8);
		note(exv());
		host.send(1'h1, 5);
		host.send(1'h0, DOM - 8);
		note(exv());
		host.send(1'h0, 16);
		e_wd = 1'h1;
		note(exv());
		bus = ~bus;
		chk(5);
		host.send(1'h1, 6);
		e_wd = 1'h0;
		note(exv());
		host.send(1'h0, 6);
		note(exv());
		host.send(1'h1, 4);
		$display("Test watchdog done");
		// Release still high as the trip arrives: the set must win
		mon.thermal_trip = 1'h1;
		e_th = 1'h1;
		host.send(1'h0, 8);
		bus = ~bus;
		chk(5);
		rel = 1'h0;
		host.send(1'h1, 2);
		mon.thermal_trip = 1'h0;
		chk(6);
		rel = 1'h1;
		e_th = 1'h0;
		chk(6);
		host.send(1'h0, 6);
		note(exv());
		host.send(1'h1, 4);
		$display("Test thermal done");
		mon.logic_side_undervolt = 1'h1;
		host.send(1'h0, 12);
		note(exv());
		host.send(1'h1, 2);
		mon.logic_side_undervolt = 1'h0;
		wait_func();
		chk(6);
		mon.bus_side_undervolt = 1'h1;
		bus = 1'h1;
		chk(12);
		mon.bus_side_undervolt = 1'h0;
		wait_func();
		chk(6);
		$display("Test supply done");
		nrst = 1'h0;
		repeat (2) @(negedge clk);
		note(8'h21);
		nrst = 1'h1;
		wait_func();
		$display("Test second reset done");
		conclude();
	end
endmodule
